// ---- ssao_pkg.sv ----
// package for the slot sample averaging and offset block
// assumes 32-bit APB register access, one register per aligned word
package ssao_pkg;

  localparam int unsigned SSAO_NUM_CH = 4;
  localparam int unsigned SSAO_ADC_W = 16;
  localparam int unsigned SSAO_SUM_W = 27;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] SSAO_IDX_AVG_CTRL = 8'h15;
  localparam logic [7:0] SSAO_IDX_A_CH1 = 8'h18;
  localparam logic [7:0] SSAO_IDX_A_CH2 = 8'h19;
  localparam logic [7:0] SSAO_IDX_A_CH3 = 8'h1a;
  localparam logic [7:0] SSAO_IDX_A_CH4 = 8'h1b;
  localparam logic [7:0] SSAO_IDX_B_CH1 = 8'h1e;
  localparam logic [7:0] SSAO_IDX_B_CH2 = 8'h1f;
  localparam logic [7:0] SSAO_IDX_B_CH3 = 8'h20;
  // no offset is known for the fourth channel of the second slot
  localparam logic [7:0] SSAO_IDX_B_CH4 = 8'h21;
  localparam logic [7:0] SSAO_IDX_STATUS = 8'h30;

  localparam int unsigned SSAO_A_AVG_LSB = 4;
  localparam int unsigned SSAO_B_AVG_LSB = 8;
  localparam logic [2:0] SSAO_A_AVG_RST = 3'h0;
  localparam logic [2:0] SSAO_B_AVG_RST = 3'h6;
  localparam logic [15:0] SSAO_OFFSET_RST = 16'h2000;
  localparam int unsigned SSAO_ACC_CNT_W = 7;

  function automatic logic [9:0] ssao_byte_addr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

endpackage

// ---- ssao_accum.sv ----
// one slot accumulator: offset subtraction, summing and power-of-two averaging
// assumes samples arrive as single-cycle valid pulses on the system clock
module ssao_accum
  import ssao_pkg::*;
#(
  parameter int unsigned ADC_W = SSAO_ADC_W,
  parameter int unsigned SUM_W = SSAO_SUM_W,
  parameter int unsigned NUM_CH = SSAO_NUM_CH
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // configuration
  input wire logic [2:0] i_avg_code,
  input wire logic [NUM_CH*ADC_W-1:0] i_offsets,
  // sample stream
  input wire logic i_smp_valid,
  input wire logic [NUM_CH*ADC_W-1:0] i_smp_data,
  // results
  output logic o_res_valid,
  output logic [NUM_CH*SUM_W-1:0] o_res_sum,
  output logic [NUM_CH*ADC_W-1:0] o_res_avg
);

  logic [SSAO_ACC_CNT_W-1:0] cnt_q;
  logic [SUM_W-1:0] acc_q [NUM_CH];
  logic [SSAO_ACC_CNT_W-1:0] last_cnt;
  logic [SUM_W-1:0] nxt [NUM_CH];

  // averaging group is 2**code samples
  assign last_cnt = SSAO_ACC_CNT_W'((1 << i_avg_code) - 1);

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      // offset subtracted from raw sample first, negative results clip to zero
      if (i_smp_data[c*ADC_W +: ADC_W] > i_offsets[c*ADC_W +: ADC_W]) begin
        nxt[c] = acc_q[c] + SUM_W'(i_smp_data[c*ADC_W +: ADC_W] - i_offsets[c*ADC_W +: ADC_W]);
      end else begin
        nxt[c] = acc_q[c];
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      cnt_q <= '0;
      for (int c = 0; c < NUM_CH; c++) acc_q[c] <= '0;
    end else if (i_smp_valid) begin
      if (cnt_q >= last_cnt) begin
        cnt_q <= '0;
        for (int c = 0; c < NUM_CH; c++) acc_q[c] <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
        for (int c = 0; c < NUM_CH; c++) acc_q[c] <= nxt[c];
      end
    end
  end

  // one result per group, decimating the rate
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_res_valid <= 1'b0;
      o_res_sum <= '0;
      o_res_avg <= '0;
    end else begin
      o_res_valid <= i_smp_valid && (cnt_q >= last_cnt);
      if (i_smp_valid && (cnt_q >= last_cnt)) begin
        for (int c = 0; c < NUM_CH; c++) begin
          o_res_sum[c*SUM_W +: SUM_W] <= nxt[c];
          // average by shifting by the code
          o_res_avg[c*ADC_W +: ADC_W] <= ADC_W'(nxt[c] >> i_avg_code);
        end
      end
    end
  end

endmodule

// ---- ssao_top.sv ----
// top of the slot sample averaging and offset block with its APB register file
// assumes the sample source runs on i_clk_sys; outputs feed data registers elsewhere
//
// Summary of operation
// - codes 3..7 select 8, 16, 32, 64, 128 samples for both slots
// - first slot factor in control bits [6:4], reset zero
// - each channel's offset subtracted from raw sample before processing
// - first slot offsets at indices 0x18 to 0x1b, read/write
// - second slot channels 1..3 offsets at 0x1e, 0x1f, 0x20
// - offset registers reset to 0x2000, the typical setting
// - selected count of samples summed; sum and average both given
// - each slot's result rate decimated by its averaging factor
// - second slot factor in control bits [10:8], reset code 6
module ssao_top
  import ssao_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // sample streams
  input wire logic i_a_valid,
  input wire logic [63:0] i_a_data,
  input wire logic i_b_valid,
  input wire logic [63:0] i_b_data,
  // results
  output logic o_a_valid,
  output logic [107:0] o_a_sum,
  output logic [63:0] o_a_avg,
  output logic o_b_valid,
  output logic [107:0] o_b_sum,
  output logic [63:0] o_b_avg
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [2:0] first_slot_average_factor_q;
  logic [2:0] second_slot_average_factor_q;
  logic [15:0] first_slot_chan1_offset_q;
  logic [15:0] first_slot_chan2_offset_q;
  logic [15:0] first_slot_chan3_offset_q;
  logic [15:0] first_slot_chan4_offset_q;
  logic [15:0] second_slot_chan1_offset_q;
  logic [15:0] second_slot_chan2_offset_q;
  logic [15:0] second_slot_chan3_offset_q;
  logic [15:0] second_slot_chan4_offset_q;
  logic [15:0] a_groups_q;
  logic [15:0] b_groups_q;
  logic wr_en;
  logic rd_en;
  logic [9:0] addr;
  logic hit;
  logic [31:0] rdata;
  logic a_res_valid;
  logic b_res_valid;
  logic [107:0] a_sum;
  logic [107:0] b_sum;
  logic [63:0] a_avg;
  logic [63:0] b_avg;
  // decoded selects and write strobes
  logic sel_ctrl;
  logic sel_a_ch1;
  logic sel_a_ch2;
  logic sel_a_ch3;
  logic sel_a_ch4;
  logic sel_b_ch1;
  logic sel_b_ch2;
  logic sel_b_ch3;
  logic sel_b_ch4;
  logic wr_ctrl;
  logic wr_a_ch1;
  logic wr_a_ch2;
  logic wr_a_ch3;
  logic wr_a_ch4;
  logic wr_b_ch1;
  logic wr_b_ch2;
  logic wr_b_ch3;
  logic wr_b_ch4;
  logic [15:0] wr_word;
  logic [63:0] a_offsets;
  logic [63:0] b_offsets;

  assign addr = i_paddr[11:2];
  // zero wait-state access: pready is high in every access phase
  assign wr_en = i_psel && i_penable && i_pwrite && o_pready;
  assign rd_en = i_psel && !i_penable && !i_pwrite;
  assign wr_word = i_pwdata[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  // true when the word index on the bus names the given register
  function automatic logic sel_reg(input logic [9:0] word, input logic [7:0] idx);
    return word == {2'b00, idx};
  endfunction

  assign sel_ctrl = sel_reg(addr, SSAO_IDX_AVG_CTRL);
  assign sel_a_ch1 = sel_reg(addr, SSAO_IDX_A_CH1);
  assign sel_a_ch2 = sel_reg(addr, SSAO_IDX_A_CH2);
  assign sel_a_ch3 = sel_reg(addr, SSAO_IDX_A_CH3);
  assign sel_a_ch4 = sel_reg(addr, SSAO_IDX_A_CH4);
  assign sel_b_ch1 = sel_reg(addr, SSAO_IDX_B_CH1);
  assign sel_b_ch2 = sel_reg(addr, SSAO_IDX_B_CH2);
  assign sel_b_ch3 = sel_reg(addr, SSAO_IDX_B_CH3);
  assign sel_b_ch4 = sel_reg(addr, SSAO_IDX_B_CH4);

  // a write takes effect only at the access edge
  assign wr_ctrl = wr_en && sel_ctrl;
  assign wr_a_ch1 = wr_en && sel_a_ch1;
  assign wr_a_ch2 = wr_en && sel_a_ch2;
  assign wr_a_ch3 = wr_en && sel_a_ch3;
  assign wr_a_ch4 = wr_en && sel_a_ch4;
  assign wr_b_ch1 = wr_en && sel_b_ch1;
  assign wr_b_ch2 = wr_en && sel_b_ch2;
  assign wr_b_ch3 = wr_en && sel_b_ch3;
  assign wr_b_ch4 = wr_en && sel_b_ch4;

  // offsets of one slot side by side, channel 1 lowest
  assign a_offsets = {first_slot_chan4_offset_q, first_slot_chan3_offset_q,
                      first_slot_chan2_offset_q, first_slot_chan1_offset_q};
  assign b_offsets = {second_slot_chan4_offset_q, second_slot_chan3_offset_q,
                      second_slot_chan2_offset_q, second_slot_chan1_offset_q};

  ////////////////////////////////////////////////////////////////////////////
  // register read

  always_comb begin
    hit = 1'b1;
    rdata = 32'h0000_0000;
    case (addr)
      ssao_byte_addr(SSAO_IDX_AVG_CTRL) >> 2:
        rdata = {21'h00_0000, second_slot_average_factor_q, 1'b0,
                 first_slot_average_factor_q, 4'h0};
      ssao_byte_addr(SSAO_IDX_A_CH1) >> 2: rdata = {16'h0000, first_slot_chan1_offset_q};
      ssao_byte_addr(SSAO_IDX_A_CH2) >> 2: rdata = {16'h0000, first_slot_chan2_offset_q};
      ssao_byte_addr(SSAO_IDX_A_CH3) >> 2: rdata = {16'h0000, first_slot_chan3_offset_q};
      ssao_byte_addr(SSAO_IDX_A_CH4) >> 2: rdata = {16'h0000, first_slot_chan4_offset_q};
      ssao_byte_addr(SSAO_IDX_B_CH1) >> 2: rdata = {16'h0000, second_slot_chan1_offset_q};
      ssao_byte_addr(SSAO_IDX_B_CH2) >> 2: rdata = {16'h0000, second_slot_chan2_offset_q};
      ssao_byte_addr(SSAO_IDX_B_CH3) >> 2: rdata = {16'h0000, second_slot_chan3_offset_q};
      ssao_byte_addr(SSAO_IDX_B_CH4) >> 2: rdata = {16'h0000, second_slot_chan4_offset_q};
      ssao_byte_addr(SSAO_IDX_STATUS) >> 2: rdata = {b_groups_q, a_groups_q};
      default: hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // register write; reserved control bits are ignored

  // averaging codes of both slots
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      first_slot_average_factor_q <= SSAO_A_AVG_RST;
    end else if (wr_ctrl) begin
      first_slot_average_factor_q <= i_pwdata[SSAO_A_AVG_LSB +: 3];
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      second_slot_average_factor_q <= SSAO_B_AVG_RST;
    end else if (wr_ctrl) begin
      second_slot_average_factor_q <= i_pwdata[SSAO_B_AVG_LSB +: 3];
    end
  end

  // first slot offsets
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      first_slot_chan1_offset_q <= SSAO_OFFSET_RST;
    end else if (wr_a_ch1) begin
      first_slot_chan1_offset_q <= wr_word;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      first_slot_chan2_offset_q <= SSAO_OFFSET_RST;
    end else if (wr_a_ch2) begin
      first_slot_chan2_offset_q <= wr_word;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      first_slot_chan3_offset_q <= SSAO_OFFSET_RST;
    end else if (wr_a_ch3) begin
      first_slot_chan3_offset_q <= wr_word;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      first_slot_chan4_offset_q <= SSAO_OFFSET_RST;
    end else if (wr_a_ch4) begin
      first_slot_chan4_offset_q <= wr_word;
    end
  end

  // second slot offsets; the fourth channel's index is a local choice
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      second_slot_chan1_offset_q <= SSAO_OFFSET_RST;
    end else if (wr_b_ch1) begin
      second_slot_chan1_offset_q <= wr_word;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      second_slot_chan2_offset_q <= SSAO_OFFSET_RST;
    end else if (wr_b_ch2) begin
      second_slot_chan2_offset_q <= wr_word;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      second_slot_chan3_offset_q <= SSAO_OFFSET_RST;
    end else if (wr_b_ch3) begin
      second_slot_chan3_offset_q <= wr_word;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      second_slot_chan4_offset_q <= SSAO_OFFSET_RST;
    end else if (wr_b_ch4) begin
      second_slot_chan4_offset_q <= wr_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: zero wait states, ready in the first access cycle

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
    end
  end

  // unmapped index answers with an error, the write is dropped
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_pslverr <= 1'b0;
    end else begin
      o_pslverr <= i_psel && !i_penable && !hit;
    end
  end

  // read data is taken in the setup cycle and holds until the next read
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      o_prdata <= rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slot datapaths

  ssao_accum u_acc_a (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_avg_code(first_slot_average_factor_q),
    .i_offsets(a_offsets),
    .i_smp_valid(i_a_valid),
    .i_smp_data(i_a_data),
    .o_res_valid(a_res_valid),
    .o_res_sum(a_sum),
    .o_res_avg(a_avg)
  );

  ssao_accum u_acc_b (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_avg_code(second_slot_average_factor_q),
    .i_offsets(b_offsets),
    .i_smp_valid(i_b_valid),
    .i_smp_data(i_b_data),
    .o_res_valid(b_res_valid),
    .o_res_sum(b_sum),
    .o_res_avg(b_avg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // result outputs, one register stage after each slot datapath

  // slot a results
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_a_valid <= 1'b0;
      o_a_sum <= '0;
      o_a_avg <= '0;
    end else begin
      o_a_valid <= a_res_valid;
      o_a_sum <= a_sum;
      o_a_avg <= a_avg;
    end
  end

  // slot b results
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_b_valid <= 1'b0;
      o_b_sum <= '0;
      o_b_avg <= '0;
    end else begin
      o_b_valid <= b_res_valid;
      o_b_sum <= b_sum;
      o_b_avg <= b_avg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status: completed groups per slot, wrapping

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      a_groups_q <= 16'h0000;
    end else if (a_res_valid) begin
      a_groups_q <= a_groups_q + 16'h0001;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      b_groups_q <= 16'h0000;
    end else if (b_res_valid) begin
      b_groups_q <= b_groups_q + 16'h0001;
    end
  end

endmodule

// ---- ssao_top_props.sv ----
// checker for the apb and result ports of the averaging block
// assumes one clock domain with an asynchronous active-high reset
module ssao_top_props (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // samples and results
  input wire logic i_a_valid,
  input wire logic i_b_valid,
  input wire logic o_a_valid,
  input wire logic o_b_valid,
  input wire logic [107:0] o_a_sum,
  input wire logic [107:0] o_b_sum,
  input wire logic [63:0] o_a_avg
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_access;
    i_psel && i_penable;
  endsequence
  chk_pready_zero_wait: assert property (s_setup |=> o_pready)
    else $error("pready missing in first access cycle");
  chk_pready_in_access: assert property (o_pready |-> s_access)
    else $error("pready outside an access cycle");
  chk_slverr_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  chk_a_valid_cause: assert property (o_a_valid |-> $past(i_a_valid, 2))
    else $error("slot a result not two cycles after a sample");
  chk_b_valid_cause: assert property (o_b_valid |-> $past(i_b_valid, 2))
    else $error("slot b result not two cycles after a sample");
  chk_a_sum_hold: assert property ($changed(o_a_sum) |-> o_a_valid)
    else $error("slot a sum moved without a result");
  chk_b_sum_hold: assert property ($changed(o_b_sum) |-> o_b_valid)
    else $error("slot b sum moved without a result");
  chk_a_avg_hold: assert property ($changed(o_a_avg) |-> o_a_valid)
    else $error("slot a average moved without a result");
endmodule

bind ssao_top ssao_top_props i_ssao_top_props (.i_clk_sys, .i_reset, .i_psel, .i_penable,
  .o_pready, .o_pslverr, .i_a_valid, .i_b_valid, .o_a_valid, .o_b_valid, .o_a_sum, .o_b_sum,
  .o_a_avg);

// ---- ssao_smp_src.sv ----
// sample source standing in for the converter and timing core of one slot
// assumes samples are taken at the rising edge of i_clk_sys
module ssao_smp_src (
  // clock
  input wire logic i_clk_sys,
  // sample stream
  output logic o_valid,
  output logic [63:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_valid = 1'b0;
    o_data = 64'h0;
  end
  // n samples of one value, gap idle cycles after each; idle data is scrambled
  task automatic burst(input logic [63:0] d, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk_sys);
      o_valid <= 1'b1;
      o_data <= d;
      repeat (gap) begin
        @(posedge i_clk_sys);
        o_valid <= 1'b0;
        o_data <= ~d;
      end
    end
    @(posedge i_clk_sys);
    o_valid <= 1'b0;
    o_data <= ~d;
  endtask
endmodule

// ---- test_slot_sample_average_offset.sv ----
// self-checking bench for the averaging block over apb and two sample sources
// assumes ssao_top, ssao_smp_src and the checker bind are compiled before it
module test_slot_sample_average_offset import ssao_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, i_a_valid, i_b_valid, o_a_valid, o_b_valid;
  logic [63:0] i_a_data, i_b_data, o_a_avg, o_b_avg;
  logic [107:0] o_a_sum, o_b_sum;
  logic [15:0] offs[8];
  logic [7:0] idx_t[8] = '{SSAO_IDX_A_CH1, SSAO_IDX_A_CH2, SSAO_IDX_A_CH3, SSAO_IDX_A_CH4,
    SSAO_IDX_B_CH1, SSAO_IDX_B_CH2, SSAO_IDX_B_CH3, SSAO_IDX_B_CH4};
  int error_cnt = 0;
  int cmp_count = 0;
  int va_cnt = 0;
  int vb_cnt = 0;
  ssao_top i_ssao_top (.i_clk_sys, .i_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_a_valid, .i_a_data, .i_b_valid,
    .i_b_data, .o_a_valid, .o_a_sum, .o_a_avg, .o_b_valid, .o_b_sum, .o_b_avg);
  ssao_smp_src i_ssao_smp_src_a (.i_clk_sys, .o_valid(i_a_valid), .o_data(i_a_data));
  ssao_smp_src i_ssao_smp_src_b (.i_clk_sys, .o_valid(i_b_valid), .o_data(i_b_data));
  always #2 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    if (o_a_valid === 1'b1) va_cnt <= va_cnt + 1;
    if (o_b_valid === 1'b1) vb_cnt <= vb_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  task results;
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd, input logic eerr,
    input logic [31:0] exp);
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= {2'b00, idx, 2'b00};
    i_pwdata <= wd;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    // a wait for the answer ends at pready; only the watchdog bounds it
    do begin
      @(posedge i_clk_sys);
    end while (o_pready !== 1'b1);
    chk({31'h0, o_pslverr}, {31'h0, eerr});
    if (!w) chk(o_prdata, exp);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  function automatic logic [15:0] net(input logic [15:0] d, input logic [15:0] o);
    return (d > o) ? d - o : 16'h0000;
  endfunction
  // one whole group on a slot, then its single result is compared channel by channel
  task grp(input int sb, input int code, input int gap);
    int n, c0;
    logic [63:0] d;
    logic [26:0] s;
    n = 1 << code;
    for (int c = 0; c < 4; c++)
      d[16*c +: 16] = (c == 3 && code == 0) ? offs[sb*4+c] - 16'h1 :
        offs[sb*4+c] + 16'(16'h40 * (c + 1) + code);
    c0 = sb ? vb_cnt : va_cnt;
    if (sb) i_ssao_smp_src_b.burst(d, n, gap);
    else i_ssao_smp_src_a.burst(d, n, gap);
    repeat (4) @(posedge i_clk_sys);
    chk(32'((sb ? vb_cnt : va_cnt) - c0), 32'h1);
    for (int c = 0; c < 4; c++) begin
      s = 27'(n) * 27'(net(d[16*c +: 16], offs[sb*4+c]));
      chk(32'(sb ? o_b_sum[27*c +: 27] : o_a_sum[27*c +: 27]), 32'(s));
      chk(32'(sb ? o_b_avg[16*c +: 16] : o_a_avg[16*c +: 16]), 32'(s >> code));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    apb(0, SSAO_IDX_AVG_CTRL, 32'h0, 0, 32'h00000600);
    for (int i = 0; i < 8; i++) apb(0, idx_t[i], 32'h0, 0, 32'h00002000);
    for (int i = 0; i < 8; i++) begin
      offs[i] = 16'h1000 + 16'(16'h0111 * i);
      apb(1, idx_t[i], {16'hffff, offs[i]}, 0, 32'h0);
    end
    apb(1, 8'h16, 32'h0000ffff, 1, 32'h0);
    apb(0, 8'h40, 32'h0, 1, 32'h0);
    for (int i = 0; i < 8; i++) apb(0, idx_t[i], 32'h0, 0, {16'h0, offs[i]});
    for (int k = 0; k < 8; k++) begin
      apb(1, SSAO_IDX_AVG_CTRL, {21'h0, 3'h6, 1'b0, 3'(k), 4'h0}, 0, 32'h0);
      apb(0, SSAO_IDX_AVG_CTRL, 32'h0, 0, {21'h0, 3'h6, 1'b0, 3'(k), 4'h0});
      grp(0, k, (k == 5) ? 2 : 0);
    end
    for (int k = 3; k < 8; k++) begin
      apb(1, SSAO_IDX_AVG_CTRL, {21'h0, 3'(k), 1'b0, 3'h0, 4'h0}, 0, 32'h0);
      grp(1, k, (k == 4) ? 1 : 0);
    end
    // status word: eight first slot groups, five second slot groups
    apb(0, SSAO_IDX_STATUS, 32'h0, 0, 32'h0005_0008);
    results;
  end
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    results;
  end
endmodule
